/* File: core/vccd_pkg.sv */
package vccd_pkg;
  localparam int             APB_AW       = 12;
  localparam int             IDX_W        = 10;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CAL_CTRL = 10'h018;
  localparam logic [IDX_W-1:0] IDX_RDBACK   = 10'h01F;
  localparam logic [IDX_W-1:0] IDX_CH_BASE  = 10'h190;
  localparam logic [IDX_W-1:0] IDX_VDIV     = 10'h1E0;
  localparam logic [IDX_W-1:0] IDX_SRC_SEL  = 10'h1E1;
  localparam logic [IDX_W-1:0] IDX_UPDATE   = 10'h232;
  localparam int             CH_STRIDE    = 3;
  localparam int             NUM_CH       = 3;
  // field positions
  localparam int             CAL_START_BIT = 0;
  localparam int             CAL_DIV_LSB   = 1;
  localparam int             CAL_DONE_BIT  = 6;
  localparam int             UPD_BIT       = 0;
  localparam int             BYPASS_BIT    = 7;
  localparam int             START_HI_BIT  = 5;
  localparam int             DCCOFF_BIT    = 0;
  // reset values
  localparam logic [2:0]     CAL_CTRL_RST = 3'h0;
  localparam logic [1:0]     SRC_RST      = 2'h0;
  localparam logic [2:0]     VDIV_RST     = 3'h0;
  localparam logic [7:0]     CH_MN_RST    = 8'h00;
  localparam logic [6:0]     CH_CTL_RST   = 7'h00;
  localparam logic           DCCOFF_RST   = 1'b0;
  // calibration timing and post-divider ratio range
  localparam logic [12:0]    CAL_CYCLES   = 13'd4400;
  localparam logic [4:0]     CAL_DIV_0    = 5'h02;
  localparam logic [4:0]     CAL_DIV_1    = 5'h04;
  localparam logic [4:0]     CAL_DIV_2    = 5'h08;
  localparam logic [4:0]     CAL_DIV_3    = 5'h10;
  localparam logic [2:0]     VDIV_MIN     = 3'h2;
  localparam logic [2:0]     VDIV_MAX     = 3'h6;

  typedef enum logic [1:0] {
    SRC_EXT_DIV = 2'h0,
    SRC_EXT_DIR = 2'h1,
    SRC_VCO_DIV = 2'h2,
    SRC_BAD     = 2'h3
  } vccd_src_t;

  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_RELEASE} vccd_cal_st_t;
endpackage : vccd_pkg

/* File: core/vccd_chdiv.sv */
`timescale 1ns/1ps
module vccd_chdiv (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // divider input clock, as level and edges
  input  wire logic       in_level,
  input  wire logic       in_rise,
  input  wire logic       in_fall,
  // configuration
  input  wire logic       hold,
  input  wire logic       bypass,
  input  wire logic [3:0] m_low,
  input  wire logic [3:0] n_high,
  input  wire logic       dcc_off,
  input  wire logic       start_high,
  input  wire logic [4:0] phase,
  // divided clock
  output logic            out_level
);
  import vccd_pkg::*;

  logic       run_reg;
  logic       ph_hi_reg;
  logic       pend_reg;
  logic [4:0] dly_reg;
  logic [3:0] cnt_reg;

  wire [3:0] len     = ph_hi_reg ? n_high : m_low;
  wire       dcc_act = ~dcc_off && ({1'b0, m_low} == ({1'b0, n_high} + 5'h01));
  wire       ph_end  = run_reg && in_rise && (cnt_reg == len);

  // phase counter: each phase lasts len+1 input cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg   <= 1'b0;
      ph_hi_reg <= 1'b0;
      dly_reg   <= 5'h00;
      cnt_reg   <= 4'h0;
    end else if (hold || bypass) begin
      run_reg   <= 1'b0;
      ph_hi_reg <= start_high;
      dly_reg   <= phase;
      cnt_reg   <= 4'h0;
    end else if (in_rise && !run_reg) begin
      if (dly_reg == 5'h00) begin
        run_reg <= 1'b1;
        cnt_reg <= 4'h0;
      end else begin
        dly_reg <= dly_reg - 5'h01;
      end
    end else if (ph_end) begin
      ph_hi_reg <= ~ph_hi_reg;
      cnt_reg   <= 4'h0;
    end else if (in_rise) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // output: high-to-low slips half an input cycle when correcting odd ratios
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_level <= 1'b0;
      pend_reg  <= 1'b0;
    end else if (bypass && !hold) begin
      out_level <= in_level;
      pend_reg  <= 1'b0;
    end else if (hold) begin
      out_level <= start_high;
      pend_reg  <= 1'b0;
    end else if (ph_end && ph_hi_reg && dcc_act) begin
      pend_reg  <= 1'b1;
    end else if (pend_reg && in_fall) begin
      out_level <= 1'b0;
      pend_reg  <= 1'b0;
    end else if (ph_end) begin
      out_level <= ~ph_hi_reg;
    end else if (run_reg && !pend_reg) begin
      out_level <= ph_hi_reg;
    end
  end
endmodule : vccd_chdiv

/* File: core/vccd_top.sv */
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module vccd_top (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic [vccd_pkg::APB_AW-1:0] paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // reference divider output and clock sources
  input  wire logic                        pfd_in,
  input  wire logic                        vco_in,
  input  wire logic                        ext_in,
  // distribution outputs and loop control
  output logic      [5:0]                  clk_out,
  output logic                             cal_sync_hold,
  output logic                             loop_closed
);
  import vccd_pkg::*;

  // shadow (written) and active (after update) copies
  logic [2:0] sh_cal_reg;
  logic [2:0] act_cal_reg;
  logic [1:0] sh_src_reg;
  logic [1:0] act_src_reg;
  logic [2:0] sh_vdiv_reg;
  logic [2:0] act_vdiv_reg;
  logic [7:0] sh_mn_reg  [NUM_CH];
  logic [7:0] act_mn_reg [NUM_CH];
  logic [6:0] sh_ctl_reg [NUM_CH];
  logic [6:0] act_ctl_reg[NUM_CH];
  logic       sh_dcc_reg [NUM_CH];
  logic       act_dcc_reg[NUM_CH];

  // calibration state
  vccd_cal_st_t cal_st_reg;
  logic [4:0]   div_cnt_reg;
  logic [12:0]  cyc_cnt_reg;
  logic         cal_done_reg;
  logic         pfd_prev_reg;

  // distribution path state
  logic       src_prev_reg;
  logic [2:0] pd_cnt_reg;
  logic       pd_level_reg;
  logic       ch_level_reg;
  logic       ch_prev_reg;
  logic [NUM_CH-1:0] ch_out;

  // apb decode
  wire [IDX_W-1:0] idx     = paddr[APB_AW-1:2];
  wire             aligned = (paddr[1:0] == 2'h0);
  wire             setup   = psel && !penable;
  wire             wr      = psel && penable && pready && pwrite;
  wire             hit_cal = aligned && (idx == IDX_CAL_CTRL);
  wire             hit_rb  = aligned && (idx == IDX_RDBACK);
  wire             hit_src = aligned && (idx == IDX_SRC_SEL);
  wire             hit_vd  = aligned && (idx == IDX_VDIV);
  wire             hit_upd = aligned && (idx == IDX_UPDATE);
  wire [NUM_CH-1:0] hit_mn;
  wire [NUM_CH-1:0] hit_ctl;
  wire [NUM_CH-1:0] hit_dcc;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_dec
      localparam logic [IDX_W-1:0] BASE = IDX_CH_BASE + IDX_W'(CH_STRIDE * gi);
      assign hit_mn[gi]  = aligned && (idx == BASE);
      assign hit_ctl[gi] = aligned && (idx == BASE + 10'h001);
      assign hit_dcc[gi] = aligned && (idx == BASE + 10'h002);
    end
  endgenerate

  wire mapped = hit_cal || hit_rb || hit_src || hit_vd || hit_upd
                || (|hit_mn) || (|hit_ctl) || (|hit_dcc);

  // update transfer: only a one in bit 0 moves shadow to active
  wire upd_fire = wr && hit_upd && pwdata[UPD_BIT];

  // start only on a clear-to-set transition of the active start bit
  wire cal_start = upd_fire && sh_cal_reg[CAL_START_BIT]
                   && !act_cal_reg[CAL_START_BIT];

  // read mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_cal) rd_byte = {5'h00, sh_cal_reg};
    if (hit_rb)  rd_byte[CAL_DONE_BIT] = cal_done_reg;
    if (hit_src) rd_byte = {6'h00, sh_src_reg};
    if (hit_vd)  rd_byte = {5'h00, sh_vdiv_reg};
    for (int i = 0; i < NUM_CH; i++) begin
      if (hit_mn[i])  rd_byte = sh_mn_reg[i];
      if (hit_ctl[i]) rd_byte = {1'b0, sh_ctl_reg[i]};
      if (hit_dcc[i]) rd_byte = {7'h00, sh_dcc_reg[i]};
    end
  end

  // apb answer: captured in setup, so access phase is one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr <= setup && !mapped;
    end
  end

  // shadow writes; unmapped and read-only targets are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_cal_reg  <= CAL_CTRL_RST;
      sh_src_reg  <= SRC_RST;
      sh_vdiv_reg <= VDIV_RST;
    end else if (wr) begin
      if (hit_cal) sh_cal_reg  <= pwdata[2:0];
      if (hit_src) sh_src_reg  <= pwdata[1:0];
      if (hit_vd)  sh_vdiv_reg <= pwdata[2:0];
    end
  end

  // active copies follow shadows only on an update transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_cal_reg  <= CAL_CTRL_RST;
      act_src_reg  <= SRC_RST;
      act_vdiv_reg <= VDIV_RST;
    end else if (upd_fire) begin
      act_cal_reg  <= sh_cal_reg;
      act_src_reg  <= sh_src_reg;
      act_vdiv_reg <= sh_vdiv_reg;
    end
  end

  // per-channel shadow and active registers
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_chreg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sh_mn_reg[gi]  <= CH_MN_RST;
          sh_ctl_reg[gi] <= CH_CTL_RST;
          sh_dcc_reg[gi] <= DCCOFF_RST;
        end else if (wr) begin
          if (hit_mn[gi])  sh_mn_reg[gi]  <= pwdata[7:0];
          if (hit_ctl[gi]) sh_ctl_reg[gi] <= {pwdata[BYPASS_BIT], pwdata[START_HI_BIT:0]};
          if (hit_dcc[gi]) sh_dcc_reg[gi] <= pwdata[DCCOFF_BIT];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          act_mn_reg[gi]  <= CH_MN_RST;
          act_ctl_reg[gi] <= CH_CTL_RST;
          act_dcc_reg[gi] <= DCCOFF_RST;
        end else if (upd_fire) begin
          act_mn_reg[gi]  <= sh_mn_reg[gi];
          act_ctl_reg[gi] <= sh_ctl_reg[gi];
          act_dcc_reg[gi] <= sh_dcc_reg[gi];
        end
      end
    end
  endgenerate

  // calibration divisor from the two-bit field
  logic [4:0] cal_div;
  always_comb begin
    unique case (act_cal_reg[CAL_DIV_LSB +: 2])
      2'h0: cal_div = CAL_DIV_0;
      2'h1: cal_div = CAL_DIV_1;
      2'h2: cal_div = CAL_DIV_2;
      2'h3: cal_div = CAL_DIV_3;
    endcase
  end

  // the run state only advances on reference divider edges, so no reference means no progress
  wire pfd_rise = pfd_in && !pfd_prev_reg;
  wire cal_tick = pfd_rise && (div_cnt_reg == cal_div - 5'h01);
  wire cal_last = cal_tick && (cyc_cnt_reg == CAL_CYCLES - 13'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pfd_prev_reg <= 1'b0;
    else          pfd_prev_reg <= pfd_in;
  end

  // calibration sequencer; a fresh start restarts the count in any state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_st_reg    <= CAL_IDLE;
      div_cnt_reg   <= 5'h00;
      cyc_cnt_reg   <= 13'd0;
      cal_done_reg  <= 1'b0;
      cal_sync_hold <= 1'b0;
      loop_closed   <= 1'b0;
    end else if (cal_start) begin
      cal_st_reg    <= CAL_RUN;
      div_cnt_reg   <= 5'h00;
      cyc_cnt_reg   <= 13'd0;
      cal_done_reg  <= 1'b0;
      cal_sync_hold <= 1'b1;
      loop_closed   <= 1'b0;
    end else begin
      unique case (cal_st_reg)
        CAL_IDLE: ;
        CAL_RUN: begin
          if (pfd_rise) begin
            div_cnt_reg <= cal_tick ? 5'h00 : div_cnt_reg + 5'h01;
          end
          if (cal_last) begin
            cal_st_reg    <= CAL_RELEASE;
            cal_done_reg  <= 1'b1;
            cal_sync_hold <= 1'b0;
          end else if (cal_tick) begin
            cyc_cnt_reg <= cyc_cnt_reg + 13'd1;
          end
        end
        CAL_RELEASE: begin
          cal_st_reg  <= CAL_IDLE;
          loop_closed <= 1'b1;
        end
      endcase
    end
  end

  // source selection; the illegal code keeps the channels quiet
  wire src_ok   = (act_src_reg != SRC_BAD);
  wire use_pdiv = (act_src_reg == SRC_EXT_DIV) || (act_src_reg == SRC_VCO_DIV);
  wire src_lvl  = (act_src_reg == SRC_VCO_DIV) ? vco_in : ext_in;
  wire src_rise = src_lvl && !src_prev_reg;

  // post-divider ratio 2..6, out-of-range codes clamp to 6
  wire [2:0] pd_ratio = (act_vdiv_reg > (VDIV_MAX - VDIV_MIN)) ? VDIV_MAX
                        : act_vdiv_reg + VDIV_MIN;
  wire [2:0] pd_next  = (pd_cnt_reg == pd_ratio - 3'h1) ? 3'h0 : pd_cnt_reg + 3'h1;

  // post-divider: odd ratios give the uneven duty the channels may correct
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_reg <= 1'b0;
      pd_cnt_reg   <= 3'h0;
      pd_level_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_lvl;
      if (src_rise) begin
        pd_cnt_reg   <= pd_next;
        pd_level_reg <= (pd_next < (pd_ratio >> 1));
      end
    end
  end

  // channel input level and its edges
  wire ch_rise = ch_level_reg && !ch_prev_reg;
  wire ch_fall = !ch_level_reg && ch_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_level_reg <= 1'b0;
      ch_prev_reg  <= 1'b0;
    end else begin
      ch_level_reg <= src_ok && (use_pdiv ? pd_level_reg : src_lvl);
      ch_prev_reg  <= ch_level_reg;
    end
  end

  // three channel dividers, each feeding a pair of outputs
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      vccd_chdiv u_div (
        .pclk       (pclk),
        .presetn    (presetn),
        .in_level   (ch_level_reg),
        .in_rise    (ch_rise),
        .in_fall    (ch_fall),
        .hold       (cal_sync_hold),
        .bypass     (act_ctl_reg[gi][6]),
        .m_low      (act_mn_reg[gi][7:4]),
        .n_high     (act_mn_reg[gi][3:0]),
        .dcc_off    (act_dcc_reg[gi]),
        .start_high (act_ctl_reg[gi][START_HI_BIT]),
        .phase      (act_ctl_reg[gi][4:0]),
        .out_level  (ch_out[gi])
      );
    end
  endgenerate

  // both outputs of a pair come from the shared divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) clk_out <= 6'h00;
    else          clk_out <= {ch_out[2], ch_out[2], ch_out[1], ch_out[1], ch_out[0], ch_out[0]};
  end
endmodule : vccd_top

/* File: test/vccd_cal_properties.sv */
`timescale 1ns/1ps
module vccd_cal_properties
  import vccd_pkg::*;
(
  // clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  // register bus
  input wire logic [vccd_pkg::APB_AW-1:0] paddr,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  // loop and outputs
  input wire logic                        pfd_in,
  input wire logic [5:0]                  clk_out,
  input wire logic                        cal_sync_hold,
  input wire logic                        loop_closed
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // decoded accesses
  wire logic [IDX_W-1:0] idx = paddr[11:2];
  wire logic             acc = psel && penable && pready;
  wire logic             wr  = acc && pwrite;
  wire logic             upd = wr && idx == IDX_UPDATE && pwdata[UPD_BIT];
  logic                  go_reg, act_go_reg, pfd_reg, hold_reg, done_reg;
  logic [1:0]            div_reg, act_div_reg;
  logic [16:0]           edge_reg;
  // divisor is a power of two, so the edge budget is a shift
  wire logic [16:0]      total    = 17'(CAL_CYCLES) << ({1'b0, act_div_reg} + 3'h1);
  // done drops as soon as a new hold begins, so a stale done never leaks into a fresh run
  wire logic             done_now = (hold_reg || done_reg) && !cal_sync_hold;
  wire logic             start_now = upd && go_reg && !act_go_reg;
  // shadow/active copy of the start bit and a pfd edge count per calibration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {go_reg, act_go_reg, pfd_reg, hold_reg, done_reg} <= 5'h00;
      {div_reg, act_div_reg} <= 4'h0;
      edge_reg <= 17'h0;
    end else begin
      if (wr && idx == IDX_CAL_CTRL) {div_reg, go_reg} <= pwdata[2:0];
      if (upd) {act_div_reg, act_go_reg} <= {div_reg, go_reg};
      pfd_reg <= pfd_in;
      hold_reg <= cal_sync_hold;
      edge_reg <= (cal_sync_hold && !start_now) ? edge_reg + 17'(pfd_in && !pfd_reg) : 17'h0;
      done_reg <= done_now && !cal_sync_hold;
    end
  end
  sequence s_start;
    start_now;
  endsequence
  sequence s_held;
    cal_sync_hold [*4];
  endsequence
  a_sync_start: assert property (s_start |=> cal_sync_hold && !loop_closed)
    else $error("hold did not follow start update");
  a_no_self_start: assert property ($rose(cal_sync_hold) |-> $past(start_now))
    else $error("calibration began without start update");
  a_cal_length: assert property ($fell(cal_sync_hold) |-> edge_reg == total)
    else $error("calibration length wrong");
  a_outputs_static: assert property (s_held |-> $stable(clk_out))
    else $error("outputs moved during hold");
  a_loop_after: assert property ($fell(cal_sync_hold) |-> !loop_closed ##1 loop_closed)
    else $error("loop not closed after release");
  a_loop_open: assert property (cal_sync_hold |-> !loop_closed)
    else $error("loop closed during hold");
  a_done_read: assert property (acc && !pwrite && idx == IDX_RDBACK |-> prdata[CAL_DONE_BIT] == $past(done_now))
    else $error("done readback wrong");
  a_pair_equal: assert property (clk_out[0] == clk_out[1] && clk_out[2] == clk_out[3] && clk_out[4] == clk_out[5])
    else $error("channel pair differs");
  a_ready_one: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
endmodule : vccd_cal_properties

bind vccd_top vccd_cal_properties u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pfd_in(pfd_in),
  .clk_out(clk_out), .cal_sync_hold(cal_sync_hold), .loop_closed(loop_closed));

/* File: test/vccd_top_tb.sv */
`timescale 1ns/1ps
module vccd_top_tb;
  import vccd_pkg::*;
  localparam int LIMIT = 70000;
  // design pins
  logic              pclk, presetn, psel, penable, pwrite, pfd_in, vco_in, ext_in;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd, seed;
  logic              pready, pslverr, cal_sync_hold, loop_closed, err;
  logic [5:0]        clk_out, held;
  // model state and bookkeeping
  int                error_cnt, n_compared, cyc, hi, lo, n, m;
  int                shadow[int];
  int                exp_hi[3], exp_lo[3];

  vccd_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pfd_in(pfd_in),
    .vco_in(vco_in), .ext_in(ext_in), .clk_out(clk_out), .cal_sync_hold(cal_sync_hold),
    .loop_closed(loop_closed));

  // report counts, verdict, end of run
  task automatic tally_and_finish;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  // source clocks toggle every cycle; cycle ceiling cuts a hang
  always @(posedge pclk) begin
    ext_in <= ~ext_in;
    vco_in <= ~vco_in;
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; the wait ends only at pready or the ceiling
  task automatic apb(logic w, logic [IDX_W-1:0] idx, logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && (idx == IDX_CAL_CTRL || idx == IDX_SRC_SEL)) shadow[idx] = d & (idx == IDX_CAL_CTRL ? 7 : 3);
  endtask : apb

  task automatic rdchk(logic [IDX_W-1:0] idx);
    apb(1'b0, idx, 8'h00);
    chk(rd, shadow.exists(idx) ? shadow[idx] : 0);
  endtask : rdchk

  task automatic upd;
    apb(1'b1, IDX_UPDATE, 8'h01);
  endtask : upd

  task automatic pulses(int k);
    repeat (k) begin
      pfd_in <= 1'b1;
      @(posedge pclk);
      pfd_in <= 1'b0;
      @(posedge pclk);
    end
  endtask : pulses

  // one full calibration of the given pfd edge count, with a stall near the end
  task automatic run_cal(int total, logic [5:0] hv);
    repeat (3) @(posedge pclk);
    chk({cal_sync_hold, loop_closed}, 2'h2);
    chk(clk_out, hv);
    apb(1'b0, IDX_RDBACK, 8'h00);
    chk(rd[CAL_DONE_BIT], 0);
    pulses(total - 1);
    repeat (60) @(posedge pclk);
    chk(cal_sync_hold, 1);
    pulses(1);
    repeat (6) @(posedge pclk);
    chk({cal_sync_hold, loop_closed}, 2'h1);
    apb(1'b0, IDX_RDBACK, 8'h00);
    chk(rd[CAL_DONE_BIT], 1);
  endtask : run_cal

  // high and low run lengths of one output, in pclk cycles
  task automatic meas(int b);
    int k;
    k = 0;
    hi = 0;
    lo = 0;
    while (clk_out[b] !== 1'b0 && k < 200) begin @(posedge pclk); k++; end
    while (clk_out[b] !== 1'b1 && k < 200) begin @(posedge pclk); k++; end
    while (clk_out[b] === 1'b1 && k < 200) begin @(posedge pclk); k++; hi++; end
    while (clk_out[b] === 1'b0 && k < 200) begin @(posedge pclk); k++; lo++; end
  endtask : meas

  initial begin
    {psel, penable, pwrite, pfd_in, vco_in, ext_in, presetn} = 7'h00;
    paddr = '0;
    pwdata = '0;
    seed = 32'hDA00EE51;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(IDX_CAL_CTRL);
    rdchk(IDX_SRC_SEL);
    rdchk(IDX_UPDATE);
    apb(1'b1, IDX_CAL_CTRL, 8'h06);
    rdchk(IDX_CAL_CTRL);
    apb(1'b0, 10'h3FF, 8'h00);
    chk(rd, 0);
    chk(err, 1);
    apb(1'b1, IDX_RDBACK, 8'h40);
    apb(1'b0, IDX_RDBACK, 8'h00);
    chk(rd[CAL_DONE_BIT], 0);
    apb(1'b1, IDX_CAL_CTRL, 8'h01);
    repeat (5) @(posedge pclk);
    chk(cal_sync_hold, 0);
    upd();
    run_cal(int'(CAL_CYCLES) * int'(CAL_DIV_0), 6'h00);
    upd();
    repeat (5) @(posedge pclk);
    chk(cal_sync_hold, 0);
    // random channel settings, the last with duty correction on
    apb(1'b1, IDX_SRC_SEL, 8'h01);
    for (int ch = 0; ch < 3; ch++) begin
      seed = xs(seed);
      n = seed[2:0];
      m = ch == 2 ? n + 1 : seed[5:3];
      apb(1'b1, 10'(IDX_CH_BASE + 3 * ch), {4'(m), 4'(n)});
      apb(1'b1, 10'(IDX_CH_BASE + 3 * ch + 1), {2'h0, seed[6], seed[11:7]});
      held[2*ch +: 2] = {2{seed[6]}};
      apb(1'b1, 10'(IDX_CH_BASE + 3 * ch + 2), {7'h00, ch != 2});
      exp_hi[ch] = 2 * (n + 1) + (ch == 2);
      exp_lo[ch] = 2 * (m + 1) - (ch == 2);
    end
    upd();
    repeat (40) @(posedge pclk);
    for (int ch = 0; ch < 3; ch++) begin
      meas(2 * ch);
      chk(hi, exp_hi[ch]);
      chk(lo, exp_lo[ch]);
    end
    // bypassed channel shows the post-divider period for both divided sources and each ratio
    apb(1'b1, IDX_CH_BASE + 10'h001, 8'h80);
    held[1:0] = 2'h0;
    for (int s = 0; s < 3; s += 2) begin
      for (int c = 0; c < 5; c++) begin
        apb(1'b1, IDX_SRC_SEL, 8'(s));
        apb(1'b1, IDX_VDIV, 8'(c));
        upd();
        repeat (30) @(posedge pclk);
        meas(0);
        chk(hi + lo, 2 * (c + 2));
      end
    end
    apb(1'b1, IDX_SRC_SEL, 8'h03);
    upd();
    repeat (10) @(posedge pclk);
    chk(clk_out[1:0], 0);
    apb(1'b1, IDX_CAL_CTRL, 8'h02);
    upd();
    apb(1'b1, IDX_CAL_CTRL, 8'h03);
    upd();
    run_cal(int'(CAL_CYCLES) * int'(CAL_DIV_1), held);
    tally_and_finish();
  end
endmodule : vccd_top_tb
